//--- tb.sv
// self-checking bench for the prescaled watchdog
`timescale 1ns/1ps
`include "wtp_regs.vh"
module tb;
   reg sys_clk_in = 1'b0;
   reg srst_in = 1'b1;
   reg [4:0] s_axi_awaddr_in = 5'h00;
   reg [4:0] s_axi_araddr_in = 5'h00;
   reg [31:0] s_axi_wdata_in = 32'h0;
   reg [3:0] s_axi_wstrb_in = 4'hf;
   reg [3:0] cfg_post_sel_in = 4'h0;
   reg s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   reg s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   reg low_power_rc_osc_clk_in = 1'b0, cfg_hard_en_in = 1'b0, cfg_long_pre_in = 1'b0;
   // one-hot: clear, switch, reset, sleep, idle, wake
   reg [5:0] evt = 6'h00;
   wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
   wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
   wire [31:0] s_axi_rdata_out;
   wire osc_enable_out, device_reset_out, wake_out, sleep_mode_out, idle_mode_out, irq_out;
   integer bad_count = 0, total_checks = 0, n_rst = 0, n_wake = 0, k, b, nr;
   reg [31:0] lfsr = 32'haddd;
   reg [31:0] rdv;
   reg [1:0] resp;

   wtp_watchdog wtp_watchdog_i (.sys_clk_in, .srst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
      .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
      .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
      .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .low_power_rc_osc_clk_in, .cfg_hard_en_in, .cfg_long_pre_in,
      .cfg_post_sel_in, .dev_reset_in(evt[2]), .clear_instr_in(evt[0]), .sleep_instr_in(evt[3]),
      .idle_instr_in(evt[4]), .wake_in(evt[5]), .clk_switch_done_in(evt[1]), .osc_enable_out,
      .device_reset_out, .wake_out, .sleep_mode_out, .idle_mode_out, .irq_out);

   always #12.5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      n_rst <= n_rst + device_reset_out;
      n_wake <= n_wake + wake_out;
   end

   function [31:0] nx(input [31:0] v);
      nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function integer ticks(input lg, input [3:0] ps);
      ticks = (lg ? 128 : 32) << ps;
   endfunction

   task print_verdict;
      begin
         if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task hang(input integer i);
      if (i < 90) begin
         bad_count = bad_count + 1;
         print_verdict;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task ev(input integer n);
      begin
         @(posedge sys_clk_in) evt <= 6'h01 << n;
         @(posedge sys_clk_in) evt <= 6'h00;
      end
   endtask
   // oscillator edges, one every 8 system cycles
   task lp(input integer n);
      repeat (n) begin
         @(posedge sys_clk_in) low_power_rc_osc_clk_in <= 1'b1;
         cyc(4);
         low_power_rc_osc_clk_in <= 1'b0;
         cyc(3);
      end
   endtask
   task wr(input [4:0] a, input [31:0] d);
      integer i;
      begin
         @(posedge sys_clk_in);
         s_axi_awaddr_in <= a;
         s_axi_wdata_in <= d;
         s_axi_awvalid_in <= 1'b1;
         s_axi_wvalid_in <= 1'b1;
         s_axi_bready_in <= 1'b1;
         for (i = 0; i < 30; i = i + 1) begin
            @(posedge sys_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            if (s_axi_bvalid_out && !s_axi_awvalid_in && !s_axi_wvalid_in) begin
               resp = s_axi_bresp_out;
               s_axi_bready_in <= 1'b0;
               i = 99;
            end
         end
         hang(i);
      end
   endtask
   task rd(input [4:0] a);
      integer i;
      begin
         @(posedge sys_clk_in);
         s_axi_araddr_in <= a;
         s_axi_arvalid_in <= 1'b1;
         s_axi_rready_in <= 1'b1;
         for (i = 0; i < 30; i = i + 1) begin
            @(posedge sys_clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            if (s_axi_rvalid_out && !s_axi_arvalid_in) begin
               rdv = s_axi_rdata_out;
               resp = s_axi_rresp_out;
               s_axi_rready_in <= 1'b0;
               i = 99;
            end
         end
         hang(i);
      end
   endtask
   // n final edges must give exactly one expiry pulse, not one edge earlier
   task run_out(input integer w);
      begin
         b = w ? n_wake : n_rst;
         lp(ticks(cfg_long_pre_in, cfg_post_sel_in) - 1);
         check(w ? n_wake : n_rst, b, "early");
         lp(1);
         cyc(3);
         check(w ? n_wake : n_rst, b + 1, "due");
      end
   endtask

   initial begin
      cyc(10);
      srst_in <= 1'b0;
      cyc(3);
      rd(`WTP_OFF_RESET_CTRL);
      check(rdv, 32'h0, "rctl");
      for (k = 0; k < 3; k = k + 1) begin
         lfsr = nx(lfsr);
         cfg_long_pre_in <= k ? lfsr[0] : 1'b0;
         cfg_post_sel_in <= k ? {2'h0, lfsr[2:1]} : 4'h0;
         wr(`WTP_OFF_RESET_CTRL, 32'h20);
         cyc(2);
         check({31'h0, osc_enable_out}, 32'h1, "osc");
         rd(`WTP_OFF_CONFIG);
         check(rdv, {23'h0, 2'b10, cfg_long_pre_in, 2'b00, cfg_post_sel_in}, "cfg");
         run_out(0);
         rd(`WTP_OFF_RESET_CTRL);
         check(rdv, 32'h10, "rctl");
         wr(`WTP_OFF_RESET_CTRL, 32'h10);
         rd(`WTP_OFF_RESET_CTRL);
         check(rdv, 32'h0, "rctl");
      end
      cfg_long_pre_in <= 1'b0;
      cfg_post_sel_in <= 4'h0;
      cfg_hard_en_in <= 1'b1;
      cyc(4);
      for (k = 0; k < 3; k = k + 1) begin
         lp(31);
         ev(k);
         run_out(0);
      end
      wr(`WTP_OFF_RESET_CTRL, 32'h1c);
      wr(`WTP_OFF_INT_STATUS, 32'h3);
      for (k = 3; k < 5; k = k + 1) begin
         lp(20);
         ev(k);
         cyc(1);
         check({30'h0, sleep_mode_out, idle_mode_out}, k == 3 ? 32'h2 : 32'h1, "mode");
         nr = n_rst;
         run_out(1);
         check(n_rst, nr, "norst");
         rd(`WTP_OFF_RESET_CTRL);
         check(rdv, k == 3 ? 32'h18 : 32'h14, "rctl");
         ev(k);
         cyc(1);
         check({30'h0, sleep_mode_out, idle_mode_out}, k == 3 ? 32'h2 : 32'h1, "mode");
         lp(20);
         ev(5);
         cyc(1);
         check({30'h0, sleep_mode_out, idle_mode_out}, 32'h0, "mode");
         run_out(0);
         wr(`WTP_OFF_RESET_CTRL, 32'h1c);
      end
      check({31'h0, irq_out}, 32'h0, "irq");
      wr(`WTP_OFF_INT_MASK, 32'h2);
      cyc(2);
      check({31'h0, irq_out}, 32'h1, "irq");
      rd(`WTP_OFF_INT_STATUS);
      check(rdv, 32'h3, "ists");
      wr(`WTP_OFF_INT_STATUS, 32'h2);
      cyc(2);
      check({31'h0, irq_out}, 32'h0, "irq");
      s_axi_wstrb_in <= 4'h0;
      wr(`WTP_OFF_INT_MASK, 32'h0);
      s_axi_wstrb_in <= 4'hf;
      rd(`WTP_OFF_INT_MASK);
      check(rdv, 32'h2, "wstrb");
      wr(5'h14, 32'hffffffff);
      check({30'h0, resp}, 32'h2, "bresp");
      rd(5'h1c);
      check({rdv[29:0], resp}, 32'h2, "rresp");
      cfg_hard_en_in <= 1'b0;
      cyc(6);
      check({31'h0, osc_enable_out}, 32'h0, "osc");
      print_verdict;
   end
endmodule

//--- wtp_divider.v
// prescaler and postscaler chain that produces the time-out pulse
`timescale 1ns/1ps
`include "wtp_regs.vh"
module wtp_divider (
   // clock and reset
   input wire sys_clk_in,
   input wire srst_in,
   // control
   input wire clear_in,
   input wire tick_in,
   input wire long_pre_in,
   input wire [3:0] post_sel_in,
   // state
   output reg [`WTP_PRE_W-1:0] pre_count_out,
   output reg [`WTP_POST_W-1:0] post_count_out,
   output reg timeout_out
);

   wire [`WTP_PRE_W-1:0] pre_lim;
   wire [`WTP_POST_W-1:0] post_lim;
   wire pre_end;

   assign pre_lim = long_pre_in ? `WTP_PRE_LIM_LONG : `WTP_PRE_LIM_SHORT; // R3
   assign post_lim = ({{(`WTP_POST_W-1){1'b0}}, 1'b1} << post_sel_in) - 1'b1; // R4
   assign pre_end = (pre_count_out == pre_lim);

   always @(posedge sys_clk_in) begin
      if (srst_in || clear_in) begin
         pre_count_out <= {`WTP_PRE_W{1'b0}};
         post_count_out <= {`WTP_POST_W{1'b0}};
         timeout_out <= 1'b0;
      end else begin
         timeout_out <= 1'b0;
         if (tick_in) begin // R1
            if (pre_end) begin
               pre_count_out <= {`WTP_PRE_W{1'b0}};
               if (post_count_out == post_lim) begin
                  post_count_out <= {`WTP_POST_W{1'b0}};
                  timeout_out <= 1'b1;
               end else begin
                  post_count_out <= post_count_out + 1'b1;
               end
            end else begin
               pre_count_out <= pre_count_out + 1'b1;
            end
         end
      end
   end

endmodule

//--- wtp_regs.vh
// register map, field positions and counts for the prescaled watchdog
// Notes on behaviour
// R1 - the counter advances only on edges of the low-power rc oscillator
// R2 - the low-power oscillator is switched on whenever the watchdog is enabled
// R3 - prescaler divides by 32 or by 128, chosen by prescale_select
// R4 - postscaler divides by 2 to the power postscale_select, 1:1 up to 1:32768
// R5 - any device reset clears counter, prescaler and postscaler
// R6 - a completed clock switch clears counter, prescaler and postscaler
// R7 - entering sleep or idle clears counter, prescaler and postscaler
// R8 - leaving sleep or idle clears counter, prescaler and postscaler again
// R9 - the watchdog clear instruction clears counter, prescaler and postscaler
// R10 - an enabled watchdog keeps counting in sleep and idle
// R11 - a time-out in sleep or idle wakes the core without a reset
// R12 - software clears the sleep or idle status bit after a watchdog wake
// R13 - hard enable runs it always; otherwise soft enable gates it, reset clears soft enable
// R14 - the time-out flag stays set until software clears it
// R15 - a time-out in normal running resets the device and sets the flag
`ifndef WTP_REGS_VH
`define WTP_REGS_VH
`define WTP_ADDR_W 5
`define WTP_OFF_RESET_CTRL 5'h00
`define WTP_OFF_INT_STATUS 5'h04
`define WTP_OFF_INT_MASK 5'h08
`define WTP_OFF_COUNT 5'h0c
`define WTP_OFF_CONFIG 5'h10
`define WTP_RC_IDLE 2
`define WTP_RC_SLEEP 3
`define WTP_RC_TIMEOUT 4
`define WTP_RC_SOFT_EN 5
`define WTP_INT_TIMEOUT 0
`define WTP_INT_WAKE 1
`define WTP_INT_W 2
`define WTP_RC_RESET 6'h00
`define WTP_PRE_W 7
`define WTP_POST_W 15
`define WTP_PRE_LIM_SHORT 7'h1f
`define WTP_PRE_LIM_LONG 7'h7f
`define WTP_RESP_OKAY 2'b00
`define WTP_RESP_SLVERR 2'b10
`endif

//--- wtp_sync.v
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module wtp_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire sys_clk_in,
   input wire srst_in,
   // pins
   input wire [WIDTH-1:0] d_in,
   // synchronised levels
   output wire [WIDTH-1:0] q_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta;
         reg stable;
         always @(posedge sys_clk_in) begin
            if (srst_in) begin
               meta <= 1'b0;
               stable <= 1'b0;
            end else begin
               meta <= d_in[i];
               stable <= meta;
            end
         end
         assign q_out[i] = stable;
      end
   endgenerate

endmodule

//--- wtp_watchdog.v
// prescaled watchdog: power modes, clear sources, status and axi4-lite slave
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "wtp_regs.vh"
module wtp_watchdog (
   // clock and reset
   input wire sys_clk_in,
   input wire srst_in,

   // axi4-lite write address
   input wire [`WTP_ADDR_W-1:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   // axi4-lite read address
   input wire [`WTP_ADDR_W-1:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,

   // oscillator and configuration pins
   input wire low_power_rc_osc_clk_in,
   input wire cfg_hard_en_in,
   input wire cfg_long_pre_in,
   input wire [3:0] cfg_post_sel_in,

   // core events, one-cycle pulses on this clock
   input wire dev_reset_in,
   input wire clear_instr_in,
   input wire sleep_instr_in,
   input wire idle_instr_in,
   input wire wake_in,
   input wire clk_switch_done_in,

   // outputs to the system
   output reg osc_enable_out,
   output reg device_reset_out,
   output reg wake_out,
   output reg sleep_mode_out,
   output reg idle_mode_out,
   output reg irq_out
);

   localparam MODE_RUN = 3'b001;
   localparam MODE_SLEEP = 3'b010;
   localparam MODE_IDLE = 3'b100;

   // synchronised pins
   wire [6:0] pins_q;
   wire low_power_rc_osc_q;
   wire hard_en;
   wire long_pre;
   wire [3:0] post_sel;
   reg low_power_rc_osc_last;
   wire tick;

   // divider chain
   wire [`WTP_PRE_W-1:0] pre_count;
   wire [`WTP_POST_W-1:0] post_count;
   wire timeout;
   reg wd_clear;

   // state
   reg [2:0] mode;
   reg [2:0] next_mode;
   reg soft_en;
   reg timeout_flag;
   reg sleep_flag;
   reg idle_flag;
   reg [`WTP_INT_W-1:0] int_status;
   reg [`WTP_INT_W-1:0] int_mask;
   wire enabled;
   reg wd_reset;
   reg wd_wake;

   // bus side
   reg aw_got;
   reg w_got;
   reg [`WTP_ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire wr_go;
   wire wr_lo;
   reg wr_rc;
   reg wr_st;
   reg wr_mask;
   reg wr_hit;
   reg [31:0] rd_data;
   reg rd_hit;

   wtp_sync #(
      .WIDTH(7)
   ) u_sync (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .d_in({cfg_post_sel_in, cfg_long_pre_in, cfg_hard_en_in, low_power_rc_osc_clk_in}),
      .q_out(pins_q)
   );

   assign low_power_rc_osc_q = pins_q[0];
   assign hard_en = pins_q[1];
   assign long_pre = pins_q[2];
   assign post_sel = pins_q[6:3];

   // rising edge of the oscillator, taken from the settled stage only
   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         low_power_rc_osc_last <= 1'b0;
      end else begin
         low_power_rc_osc_last <= low_power_rc_osc_q;
      end
   end

   assign tick = low_power_rc_osc_q & ~low_power_rc_osc_last & enabled; // R1 R10
   assign enabled = hard_en | soft_en; // R13

   // every restart source, and a disabled watchdog, holds the chain at zero
   always @* begin
      wd_clear = ~enabled;
      if (dev_reset_in || device_reset_out) begin
         wd_clear = 1'b1; // R5
      end
      if (clk_switch_done_in) begin
         wd_clear = 1'b1; // R6
      end
      if (sleep_instr_in || idle_instr_in) begin
         wd_clear = 1'b1; // R7
      end
      if (mode != MODE_RUN && (wake_in || timeout)) begin
         wd_clear = 1'b1; // R8
      end
      if (clear_instr_in) begin
         wd_clear = 1'b1; // R9
      end
   end

   wtp_divider u_div (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .clear_in(wd_clear),
      .tick_in(tick),
      .long_pre_in(long_pre),
      .post_sel_in(post_sel),
      .pre_count_out(pre_count),
      .post_count_out(post_count),
      .timeout_out(timeout)
   );

   // power mode sequencing
   always @* begin
      next_mode = mode;
      wd_reset = 1'b0;
      wd_wake = 1'b0;
      case (mode)
         MODE_RUN: begin
            if (timeout) begin
               wd_reset = 1'b1; // R15
            end else if (sleep_instr_in) begin
               next_mode = MODE_SLEEP;
            end else if (idle_instr_in) begin
               next_mode = MODE_IDLE;
            end
         end
         MODE_SLEEP, MODE_IDLE: begin
            if (timeout) begin
               wd_wake = 1'b1; // R11
               next_mode = MODE_RUN;
            end else if (wake_in) begin
               next_mode = MODE_RUN;
            end
         end
         default: begin
            next_mode = MODE_RUN;
         end
      endcase
      if (dev_reset_in) begin
         next_mode = MODE_RUN;
      end
   end

   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         mode <= MODE_RUN;
         device_reset_out <= 1'b0;
         wake_out <= 1'b0;
         sleep_mode_out <= 1'b0;
         idle_mode_out <= 1'b0;
         osc_enable_out <= 1'b0;
      end else begin
         mode <= next_mode;
         device_reset_out <= wd_reset;
         wake_out <= wd_wake;
         sleep_mode_out <= (next_mode == MODE_SLEEP);
         idle_mode_out <= (next_mode == MODE_IDLE);
         osc_enable_out <= enabled; // R2
      end
   end

   // axi4-lite write path: address and data accepted in either order
   assign wr_go = aw_got & w_got & ~s_axi_bvalid_out;
   assign wr_lo = wr_go & w_strb[0];

   always @* begin
      wr_rc = 1'b0;
      wr_st = 1'b0;
      wr_mask = 1'b0;
      wr_hit = 1'b1;
      case (aw_addr)
         `WTP_OFF_RESET_CTRL: wr_rc = wr_lo;
         `WTP_OFF_INT_STATUS: wr_st = wr_lo;
         `WTP_OFF_INT_MASK: wr_mask = wr_lo;
         `WTP_OFF_COUNT: wr_hit = 1'b1;
         `WTP_OFF_CONFIG: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= {`WTP_ADDR_W{1'b0}};
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `WTP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end else begin
            s_axi_awready_out <= ~aw_got;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end else begin
            s_axi_wready_out <= ~w_got;
         end
         if (wr_go) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_hit ? `WTP_RESP_OKAY : `WTP_RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
      end
   end

   // status and control bits; a hardware set wins over a software clear
   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         soft_en <= 1'b0;
         timeout_flag <= 1'b0;
         sleep_flag <= 1'b0;
         idle_flag <= 1'b0;
         int_status <= {`WTP_INT_W{1'b0}};
         int_mask <= {`WTP_INT_W{1'b0}};
      end else begin
         if (dev_reset_in || wd_reset) begin
            soft_en <= 1'b0; // R13
         end else if (wr_rc) begin
            soft_en <= w_data[`WTP_RC_SOFT_EN];
         end
         timeout_flag <= (timeout_flag & ~(wr_rc & w_data[`WTP_RC_TIMEOUT]))
            | wd_reset | wd_wake; // R14 R15
         sleep_flag <= (sleep_flag & ~(wr_rc & w_data[`WTP_RC_SLEEP]))
            | (mode == MODE_RUN & sleep_instr_in & ~timeout); // R12
         idle_flag <= (idle_flag & ~(wr_rc & w_data[`WTP_RC_IDLE]))
            | (mode == MODE_RUN & idle_instr_in & ~sleep_instr_in & ~timeout); // R12
         int_status[`WTP_INT_TIMEOUT] <= (int_status[`WTP_INT_TIMEOUT]
            & ~(wr_st & w_data[`WTP_INT_TIMEOUT])) | wd_reset | wd_wake;
         int_status[`WTP_INT_WAKE] <= (int_status[`WTP_INT_WAKE]
            & ~(wr_st & w_data[`WTP_INT_WAKE])) | wd_wake;
         if (wr_mask) begin
            int_mask <= w_data[`WTP_INT_W-1:0];
         end
      end
   end

   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(int_status & int_mask);
      end
   end

   // axi4-lite read path
   always @* begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr_in)
         `WTP_OFF_RESET_CTRL: begin
            rd_data[`WTP_RC_SOFT_EN] = soft_en;
            rd_data[`WTP_RC_TIMEOUT] = timeout_flag;
            rd_data[`WTP_RC_SLEEP] = sleep_flag;
            rd_data[`WTP_RC_IDLE] = idle_flag;
         end
         `WTP_OFF_INT_STATUS: rd_data[`WTP_INT_W-1:0] = int_status;
         `WTP_OFF_INT_MASK: rd_data[`WTP_INT_W-1:0] = int_mask;
         `WTP_OFF_COUNT: rd_data[22:0] = {pre_count, 1'b0, post_count};
         `WTP_OFF_CONFIG: rd_data[8:0] = {enabled, hard_en, long_pre, mode[2:1], post_sel};
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge sys_clk_in) begin
      if (srst_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `WTP_RESP_OKAY;
      end else begin
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_data;
            s_axi_rresp_out <= rd_hit ? `WTP_RESP_OKAY : `WTP_RESP_SLVERR;
         end else if (s_axi_rvalid_out) begin
            if (s_axi_rready_in) begin
               s_axi_rvalid_out <= 1'b0;
               s_axi_arready_out <= 1'b1;
            end
         end else begin
            s_axi_arready_out <= 1'b1;
         end
      end
   end

endmodule

//--- wtp_watchdog_chk.sv
// assertion checker for the prescaled watchdog ports
`timescale 1ns/1ps
module wtp_watchdog_chk (
   // clock and reset
   input wire sys_clk_in,
   input wire srst_in,
   // oscillator, configuration and core events
   input wire low_power_rc_osc_clk_in,
   input wire cfg_hard_en_in,
   input wire dev_reset_in,
   input wire clear_instr_in,
   input wire sleep_instr_in,
   input wire idle_instr_in,
   input wire wake_in,
   input wire clk_switch_done_in,
   // system outputs
   input wire osc_enable_out,
   input wire device_reset_out,
   input wire wake_out,
   input wire sleep_mode_out,
   input wire idle_mode_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (srst_in);
   // a cleared chain cannot expire again within a few cycles
   sequence s_quiet;
      (!device_reset_out && !wake_out) [*4];
   endsequence
   sequence s_pulse_end;
      !device_reset_out;
   endsequence
   AST_DEV_RESET_CLEARS: assert property (dev_reset_in |-> ##2 s_quiet)
      else $error("device reset did not restart the chain");
   AST_SWITCH_CLEARS: assert property (clk_switch_done_in |-> ##2 s_quiet)
      else $error("clock switch did not restart the chain");
   AST_CLEAR_INSTR: assert property (clear_instr_in |-> ##2 s_quiet)
      else $error("clear instruction did not restart the chain");
   AST_SLEEP_ENTRY: assert property (sleep_instr_in |=> sleep_mode_out || device_reset_out)
      else $error("sleep not entered");
   AST_IDLE_ENTRY: assert property (idle_instr_in && !sleep_instr_in |=> idle_mode_out || device_reset_out)
      else $error("idle not entered");
   AST_WAKE_EXIT: assert property (wake_in && !sleep_instr_in && !idle_instr_in
      |=> !sleep_mode_out && !idle_mode_out)
      else $error("power mode not left on wake");
   AST_WAKE_NO_RESET: assert property (wake_out |-> !device_reset_out && $past(sleep_mode_out || idle_mode_out))
      else $error("wake pulse outside a power mode");
   AST_RUN_TIMEOUT: assert property (device_reset_out |-> !$past(sleep_mode_out || idle_mode_out)
      ##1 s_pulse_end)
      else $error("reset pulse wrong");
   AST_LOW_POWER_RC_OSC_ONLY: assert property ($stable(low_power_rc_osc_clk_in) [*8] |-> !device_reset_out && !wake_out)
      else $error("expiry without oscillator edges");
   AST_HARD_OSC: assert property (cfg_hard_en_in [*6] |-> osc_enable_out)
      else $error("oscillator off while hard enabled");
endmodule

bind wtp_watchdog wtp_watchdog_chk wtp_watchdog_chk_i (.sys_clk_in, .srst_in, .low_power_rc_osc_clk_in, .cfg_hard_en_in,
   .dev_reset_in, .clear_instr_in, .sleep_instr_in, .idle_instr_in, .wake_in, .clk_switch_done_in,
   .osc_enable_out, .device_reset_out, .wake_out, .sleep_mode_out, .idle_mode_out);
